// >>> testbench/pcs_top_bench.sv
`timescale 1ns/10ps
module pcs_top_bench;
    import pcs_pkg::*;
    localparam int TC = 8;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         pg = 1'b1;
    logic [5:0]   adr = 6'h00;
    logic         rd = 1'b0;
    logic         wr = 1'b0;
    logic [31:0]  wd = 32'h0;
    logic [31:0]  rdat;
    logic         wt;
    logic         ucl;
    logic         uw = 1'b0;
    logic         hold = 1'b0;
    logic [7:0]   uo;
    logic [7:0]   uoe;
    logic [7:0]   po;
    logic [7:0]   poe;
    logic [7:0]   ppu;
    logic [255:0] img;
    logic [3:0]   ua = 4'h0;
    logic [15:0]  uwd = 16'h0;
    logic [15:0]  urd;
    int           n_mismatch = 0;
    int           n_compared = 0;
    int           cyc = 0;
    always #2 clk = ~clk;
    pcs_top #(.T_CONFIG(TC)) DUT (
        .sys_clk_in(clk),
        .rst_n_in(rst_n),
        .power_good_in(pg),
        .address_in(adr),
        .read_in(rd),
        .write_in(wr),
        .writedata_in(wd),
        .readdata_out(rdat),
        .waitrequest_out(wt),
        .user_out_in(uo),
        .user_oe_in(uoe),
        .pad_out(po),
        .pad_oe_out(poe),
        .pad_pullup_out(ppu),
        .user_clear_out(ucl),
        .logic_image_out(img),
        .uf_addr_in(ua),
        .uf_write_in(uw),
        .uf_wdata_in(uwd),
        .uf_rdata_out(urd)
    );
    pcs_user_model u_user (
        .clk_in(clk),
        .rst_n_in(rst_n),
        .hold_in(hold),
        .pins_out(uo),
        .oe_out(uoe)
    );
    // ======================================================================
    // Bus and compare helpers.
    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    // The request is held until waitrequest is seen low at an edge.
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wt !== 1'b0 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            stop_test();
        end
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic wreg(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic chk(input string nm, input logic [5:0] a,
                       input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        cmp(nm, e, q);
    endtask
    task automatic cmd(input logic [3:0] c);
        wreg(PCS_OFS_CMD, {28'h0, c});
    endtask
    task automatic wst(input logic [2:0] s);
        logic [31:0] q;
        q = 32'hFFFF_FFFF;
        for (int i = 0; i < 40 && q[2:0] !== s; i++) begin
            bus(1'b0, PCS_OFS_STATUS, 32'h0, q);
        end
        cmp("state", {29'h0, s}, {29'h0, q[2:0]});
    endtask
    task automatic st_bit(input string nm, input int b, input logic e);
        logic [31:0] q;
        bus(1'b0, PCS_OFS_STATUS, 32'h0, q);
        cmp(nm, {31'h0, e}, {31'h0, q[b]});
    endtask
    // ======================================================================
    // Scenarios.
    task automatic t_boot;
        cmp("oe_reset", 32'h0, poe);
        wst(PCS_USER);
        cmp("oe_blank", 32'h0, poe);
        chk("id", PCS_OFS_ID, PCS_ID_CODE);
        chk("unmapped", 6'h3C, 32'h0);
        $display("test boot done");
    endtask
    task automatic t_prog;
        cmd(PCS_CMD_ENTER);
        wst(PCS_PROG);
        cmp("oe_prog", 32'h0, poe);
        cmp("pull_prog", 32'hFF, ppu);
        cmd(PCS_CMD_CHECK_ID);
        st_bit("id_ok", PCS_ST_ID_OK, 1'b1);
        cmd(PCS_CMD_ERASE);
        wreg(PCS_OFS_ADDR, 32'h0);
        wreg(PCS_OFS_DATA, 32'hA5A5);
        cmd(PCS_CMD_PROGRAM);
        cmd(PCS_CMD_SET_DONE);
        cmd(PCS_CMD_VERIFY);
        chk("verify", PCS_OFS_RDBK, 32'hA5A5);
        cmd(PCS_CMD_EXIT);
        wst(PCS_USER);
        hold <= 1'b1;
        repeat (3) @(posedge clk);
        cmp("image0", 32'hA5A5, img[15:0]);
        cmp("oe_user", 32'h35, poe);
        cmp("pad_user", uo & 8'h35, po & 8'h35);
        $display("test prog done");
    endtask
    task automatic t_clamp;
        logic [1:0] md[8] = '{PCS_PIN_CAPTURE, PCS_PIN_CAPTURE, PCS_PIN_HIGH,
            PCS_PIN_LOW, PCS_PIN_TRI, PCS_PIN_CAPTURE, PCS_PIN_TRI,
            PCS_PIN_TRI};
        for (int i = 0; i < 8; i++) begin
            wreg(PCS_OFS_PSEL, i);
            wreg(PCS_OFS_PMODE, {30'h0, md[i]});
        end
        cmd(PCS_CMD_ENTER_CLAMP);
        wst(PCS_PROG);
        cmp("oe_clamp", 32'h2D, poe);
        cmp("pad_capture", uo & 8'h21, po & 8'h21);
        cmp("pad_forced", 32'h04, po & 8'h0C);
        cmd(PCS_CMD_EXIT);
        wst(PCS_USER);
        $display("test clamp done");
    endtask
    task automatic t_bg;
        hold <= 1'b0;
        cmd(PCS_CMD_ENTER_BG);
        wst(PCS_BG);
        cmd(PCS_CMD_ERASE);
        wreg(PCS_OFS_ADDR, 32'h1);
        wreg(PCS_OFS_DATA, 32'h5A5A);
        cmd(PCS_CMD_PROGRAM);
        cmd(PCS_CMD_SET_DONE);
        hold <= 1'b1;
        repeat (3) @(posedge clk);
        cmp("oe_bg", 32'h35, poe);
        cmp("pad_bg", uo & 8'h35, po & 8'h35);
        cmp("image_bg", 32'hA5A5, img[15:0]);
        cmd(PCS_CMD_EXIT);
        wst(PCS_USER);
        cmp("image_old", 32'h0, img[31:16]);
        pg <= 1'b0;
        repeat (3) @(posedge clk);
        cmp("oe_pwroff", 32'h0, poe);
        pg <= 1'b1;
        wst(PCS_USER);
        cmp("image_new", 32'h5A5A, img[31:16]);
        cmp("image_erased", 32'h0, img[15:0]);
        $display("test background done");
    endtask
    task automatic t_reload;
        int n;
        int bad;
        n = 0;
        bad = 0;
        cmd(PCS_CMD_RELOAD_GO);
        st_bit("refused_go", PCS_ST_REFUSED, 1'b1);
        wreg(PCS_OFS_STATUS, 32'h80);
        st_bit("refused_clr", PCS_ST_REFUSED, 1'b0);
        cmd(PCS_CMD_RELOAD_ARM);
        st_bit("armed", PCS_ST_ARMED, 1'b1);
        cmd(PCS_CMD_RELOAD_GO);
        // Pads react one edge after the command lands.
        repeat (2) @(posedge clk);
        while (ucl !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
            if (poe !== 8'h00) bad++;
        end
        cmp("clear_seen", 32'h1, {31'h0, ucl});
        cmp("float_bad", 32'h0, bad);
        cmp("float_len", 32'h1, {31'h0, n + 2 >= TC});
        repeat (2) @(posedge clk);
        cmp("oe_reload", 32'h35, poe);
        $display("test reload done");
    endtask
    task automatic t_secure;
        cmd(PCS_CMD_ENTER);
        wst(PCS_PROG);
        cmd(PCS_CMD_ERASE);
        wreg(PCS_OFS_DATA, 32'h1234);
        cmd(PCS_CMD_PROGRAM);
        cmd(PCS_CMD_SET_SECURE);
        cmd(PCS_CMD_VERIFY);
        st_bit("secure", PCS_ST_SECURE, 1'b1);
        st_bit("refused_rd", PCS_ST_REFUSED, 1'b1);
        chk("rdbk", PCS_OFS_RDBK, 32'h0);
        wreg(PCS_OFS_UADDR, 32'h3);
        wreg(PCS_OFS_UDATA, 32'hBEEF);
        chk("uf_bus", PCS_OFS_UDATA, 32'hBEEF);
        ua <= 4'h3;
        repeat (2) @(posedge clk);
        cmp("uf_logic", 32'hBEEF, urd);
        ua <= 4'h5;
        uwd <= 16'h0077;
        uw <= 1'b1;
        @(posedge clk);
        uw <= 1'b0;
        repeat (2) @(posedge clk);
        cmp("uf_logic_wr", 32'h77, urd);
        wreg(PCS_OFS_UADDR, 32'h5);
        chk("uf_cross", PCS_OFS_UDATA, 32'h77);
        cmd(PCS_CMD_CHECK_ID);
        cmd(PCS_CMD_EXIT);
        wst(PCS_USER);
        st_bit("secure_kept", PCS_ST_SECURE, 1'b1);
        cmd(PCS_CMD_ENTER);
        wst(PCS_PROG);
        cmd(PCS_CMD_ERASE);
        st_bit("secure_erased", PCS_ST_SECURE, 1'b0);
        chk("uf_erased", PCS_OFS_UDATA, 32'h0);
        $display("test security done");
    endtask
    // ======================================================================
    // Verdict and run control; the ceiling is far above a normal run.
    task automatic stop_test;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_boot();
        t_prog();
        t_clamp();
        t_bg();
        t_reload();
        t_secure();
        stop_test();
    end
endmodule // pcs_top_bench

// >>> testbench/pcs_top_chk.sv
`timescale 1ns/10ps
// ==========================================================================
// Port checker.
module pcs_top_chk
    import pcs_pkg::*;
#(
    parameter int PINS     = 8,
    parameter int DW       = 16,
    parameter int T_CONFIG = 8
) (
    input wire logic            sys_clk_in,
    input wire logic            rst_n_in,
    input wire logic            power_good_in,
    input wire logic            read_in,
    input wire logic            write_in,
    input wire logic [31:0]     readdata_out,
    input wire logic            waitrequest_out,
    input wire logic [PINS-1:0] pad_oe_out,
    input wire logic [PINS-1:0] pad_pullup_out,
    input wire logic            user_clear_out,
    input wire logic [3:0]      uf_addr_in,
    input wire logic            uf_write_in,
    input wire logic [DW-1:0]   uf_wdata_in,
    input wire logic [DW-1:0]   uf_rdata_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Counts cycles of floating pads; saturates so it cannot wrap.
    int float_cnt;
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || pad_oe_out != '0) begin
            float_cnt <= 0;
        end else if (float_cnt < 1000) begin
            float_cnt <= float_cnt + 1;
        end
    end
    property p_pull;
        pad_pullup_out == ~pad_oe_out;
    endproperty
    property p_wait_one;
        $rose(read_in || write_in) |-> waitrequest_out ##1 !waitrequest_out;
    endproperty
    property p_rd_hold;
        $changed(readdata_out) |-> $past(read_in);
    endproperty
    property p_pwr_off;
        !power_good_in |-> ##2 pad_oe_out == '0;
    endproperty
    property p_pwr_up;
        $rose(power_good_in) |=> (pad_oe_out == '0) [*8];
    endproperty
    property p_clear_pulse;
        user_clear_out |=> !user_clear_out && pad_oe_out == '0;
    endproperty
    property p_clear_float;
        user_clear_out |-> float_cnt >= T_CONFIG - 1;
    endproperty
    property p_uf;
        uf_write_in && !write_in ##1 uf_addr_in == $past(uf_addr_in)
            |=> uf_rdata_out == $past(uf_wdata_in, 2);
    endproperty
    a_pull: assert property (p_pull) else $error("pull-up not inverse of oe");
    a_wait_one: assert property (p_wait_one) else $error("bad wait state");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_pwr_off: assert property (p_pwr_off) else $error("drive, power low");
    a_pwr_up: assert property (p_pwr_up) else $error("drive at power-up");
    a_clear_pulse: assert property (p_clear_pulse) else $error("bad clear");
    a_clear_float: assert property (p_clear_float) else $error("short float");
    a_uf: assert property (p_uf) else $error("user flash write lost");
    c_clear: cover property (user_clear_out);
    c_drive: cover property (pad_oe_out != '0);
    c_uf: cover property (uf_write_in);
endmodule // pcs_top_chk

bind pcs_top pcs_top_chk #(
    .PINS(PINS),
    .DW(DW),
    .T_CONFIG(T_CONFIG)
) u_chk (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .power_good_in(power_good_in),
    .read_in(read_in),
    .write_in(write_in),
    .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out),
    .pad_oe_out(pad_oe_out),
    .pad_pullup_out(pad_pullup_out),
    .user_clear_out(user_clear_out),
    .uf_addr_in(uf_addr_in),
    .uf_write_in(uf_write_in),
    .uf_wdata_in(uf_wdata_in),
    .uf_rdata_out(uf_rdata_out)
);

// >>> testbench/pcs_user_model.sv
`timescale 1ns/10ps
// ==========================================================================
// Running user design: pins change every cycle unless held still.
module pcs_user_model #(
    parameter logic [7:0] OE = 8'h35
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       hold_in,
    output logic      [7:0] pins_out,
    output logic      [7:0] oe_out
);
    assign oe_out = OE;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pins_out <= 8'h00;
        end else if (!hold_in) begin
            pins_out <= pins_out + 8'h01;
        end
    end
endmodule // pcs_user_model

// >>> verilog/pcs_pkg.sv
package pcs_pkg;

    // =====================================================================
    // Register byte offsets
    localparam logic [5:0] PCS_OFS_CMD    = 6'h00;
    localparam logic [5:0] PCS_OFS_STATUS = 6'h04;
    localparam logic [5:0] PCS_OFS_ADDR   = 6'h08;
    localparam logic [5:0] PCS_OFS_DATA   = 6'h0C;
    localparam logic [5:0] PCS_OFS_RDBK   = 6'h10;
    localparam logic [5:0] PCS_OFS_UADDR  = 6'h14;
    localparam logic [5:0] PCS_OFS_UDATA  = 6'h18;
    localparam logic [5:0] PCS_OFS_ID     = 6'h1C;
    localparam logic [5:0] PCS_OFS_PSEL   = 6'h20;
    localparam logic [5:0] PCS_OFS_PMODE  = 6'h24;

    // =====================================================================
    // Command codes written to the command register
    localparam logic [3:0] PCS_CMD_ENTER       = 4'h1;
    localparam logic [3:0] PCS_CMD_ENTER_CLAMP = 4'h2;
    localparam logic [3:0] PCS_CMD_ENTER_BG    = 4'h3;
    localparam logic [3:0] PCS_CMD_CHECK_ID    = 4'h4;
    localparam logic [3:0] PCS_CMD_ERASE       = 4'h5;
    localparam logic [3:0] PCS_CMD_PROGRAM     = 4'h6;
    localparam logic [3:0] PCS_CMD_VERIFY      = 4'h7;
    localparam logic [3:0] PCS_CMD_SET_SECURE  = 4'h8;
    localparam logic [3:0] PCS_CMD_SET_DONE    = 4'h9;
    localparam logic [3:0] PCS_CMD_EXIT        = 4'hA;
    localparam logic [3:0] PCS_CMD_RELOAD_ARM  = 4'hB;
    localparam logic [3:0] PCS_CMD_RELOAD_GO   = 4'hC;

    // =====================================================================
    // Per-pin clamp settings
    localparam logic [1:0] PCS_PIN_TRI     = 2'h0;
    localparam logic [1:0] PCS_PIN_CAPTURE = 2'h1;
    localparam logic [1:0] PCS_PIN_HIGH    = 2'h2;
    localparam logic [1:0] PCS_PIN_LOW     = 2'h3;

    // =====================================================================
    // Status bit positions
    localparam int PCS_ST_STATE   = 0;
    localparam int PCS_ST_SECURE  = 4;
    localparam int PCS_ST_DONE    = 5;
    localparam int PCS_ST_ID_OK   = 6;
    localparam int PCS_ST_REFUSED = 7;
    localparam int PCS_ST_ARMED   = 8;

    // =====================================================================
    // Modes and timing
    typedef enum logic [2:0] {
        PCS_POWERUP = 3'b000,
        PCS_CONFIG  = 3'b001,
        PCS_CLEAR   = 3'b010,
        PCS_USER    = 3'b011,
        PCS_PROG    = 3'b100,
        PCS_BG      = 3'b101
    } pcs_state_e;

    localparam int PCS_CLK_PERIOD_NS = 4;
    localparam int PCS_T_CONFIG_NS   = 450000;
    localparam int PCS_T_CONFIG_CYC  = PCS_T_CONFIG_NS / PCS_CLK_PERIOD_NS;

    // Arbitrary neutral identifier value.
    localparam logic [31:0] PCS_ID_CODE = 32'h0000_1234;

endpackage

// >>> verilog/pcs_top.sv
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module pcs_top
    import pcs_pkg::*;
#(
    parameter int PINS       = 8,
    parameter int DW         = 16,
    parameter int CFG_DEPTH  = 16,
    parameter int UF_DEPTH   = 16,
    parameter int T_CONFIG   = PCS_T_CONFIG_CYC
) (
    input  wire logic                    sys_clk_in,
    input  wire logic                    rst_n_in,
    input  wire logic                    power_good_in,
    input  wire logic [5:0]              address_in,
    input  wire logic                    read_in,
    input  wire logic                    write_in,
    input  wire logic [31:0]             writedata_in,
    output logic      [31:0]             readdata_out,
    output logic                         waitrequest_out,
    input  wire logic [PINS-1:0]         user_out_in,
    input  wire logic [PINS-1:0]         user_oe_in,
    output logic      [PINS-1:0]         pad_out,
    output logic      [PINS-1:0]         pad_oe_out,
    output logic      [PINS-1:0]         pad_pullup_out,
    output logic                         user_clear_out,
    output logic      [CFG_DEPTH*DW-1:0] logic_image_out,
    input  wire logic [3:0]              uf_addr_in,
    input  wire logic                    uf_write_in,
    input  wire logic [DW-1:0]           uf_wdata_in,
    output logic      [DW-1:0]           uf_rdata_out
);
    // =====================================================================
    // Bus slave: one wait cycle on every access
    logic       ack, wr_take, rd_cycle;
    logic [3:0] cmd;

    assign waitrequest_out = (read_in | write_in) & ~ack;
    assign wr_take  = write_in & ack;
    assign rd_cycle = read_in & ~ack;
    assign cmd      = writedata_in[3:0];

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ack <= 1'b0;
        end else begin
            ack <= (read_in | write_in) & ~ack;
        end
    end
    // =====================================================================
    // Storage
    pcs_state_e  state;
    logic [31:0] cnt;
    logic [3:0]  faddr, uaddr;
    logic [DW-1:0] fdata, rdbk;
    logic [7:0]  psel;
    logic        secure, done_flag, id_ok, refused, armed, clamp_act;
    logic        live_done;
    logic [DW-1:0] cfg_mem [CFG_DEPTH], image [CFG_DEPTH];
    logic [DW-1:0] uf      [UF_DEPTH];
    logic [1:0]  pin_mode  [PINS];
    logic [PINS-1:0] cap_val, cap_oe;
    logic        cmd_wr, in_prog, bad_cmd, erase_ok;
    assign cmd_wr   = wr_take && address_in == PCS_OFS_CMD;
    assign in_prog  = state == PCS_PROG || state == PCS_BG;
    assign erase_ok = cmd_wr && !bad_cmd && cmd == PCS_CMD_ERASE;
    always_comb begin
        bad_cmd = 1'b0;
        if (cmd_wr) begin
            case (cmd)
                PCS_CMD_ENTER, PCS_CMD_ENTER_CLAMP, PCS_CMD_ENTER_BG,
                PCS_CMD_RELOAD_ARM:
                    bad_cmd = state != PCS_USER;
                PCS_CMD_RELOAD_GO:
                    bad_cmd = state != PCS_USER || !armed;
                PCS_CMD_PROGRAM, PCS_CMD_SET_SECURE:
                    bad_cmd = !in_prog || done_flag;
                PCS_CMD_VERIFY:
                    bad_cmd = !in_prog || secure;
                default:
                    bad_cmd = !in_prog;
            endcase
        end
    end
    // =====================================================================
    // Mode sequencing
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state     <= PCS_POWERUP;
            cnt       <= 32'h0000_0000;
            clamp_act <= 1'b0;
            armed     <= 1'b0;
            id_ok     <= 1'b0;
        end else if (!power_good_in) begin
            state <= PCS_POWERUP;
            armed <= 1'b0;
        end else begin
            if (cmd_wr) begin
                armed <= cmd == PCS_CMD_RELOAD_ARM && !bad_cmd;
            end
            case (state)
                PCS_POWERUP: begin
                    state <= PCS_CONFIG;
                    cnt   <= 32'h0000_0000;
                end
                PCS_CONFIG: begin
                    cnt <= cnt + 32'h0000_0001;
                    if (cnt == 32'(T_CONFIG - 1)) begin
                        state <= PCS_CLEAR;
                    end
                end
                PCS_CLEAR: begin
                    state <= PCS_USER;
                end
                PCS_USER: begin
                    if (cmd_wr && !bad_cmd) begin
                        case (cmd)
                            PCS_CMD_ENTER, PCS_CMD_ENTER_CLAMP: begin
                                state     <= PCS_PROG;
                                clamp_act <= cmd == PCS_CMD_ENTER_CLAMP;
                                id_ok     <= 1'b0;
                            end
                            PCS_CMD_ENTER_BG: begin
                                state <= PCS_BG;
                                id_ok <= 1'b0;
                            end
                            PCS_CMD_RELOAD_GO: begin
                                state <= PCS_CONFIG;
                                cnt   <= 32'h0000_0000;
                            end
                            default: state <= PCS_USER;
                        endcase
                    end
                end
                PCS_PROG, PCS_BG: begin
                    if (cmd_wr && cmd == PCS_CMD_CHECK_ID) begin
                        id_ok <= 1'b1;
                    end
                    if (cmd_wr && cmd == PCS_CMD_EXIT) begin
                        // Foreground exit reconfigures; background keeps
                        // the old design until a power cycle or a reload.
                        state <= (state == PCS_BG) ? PCS_USER : PCS_CONFIG;
                        cnt   <= 32'h0000_0000;
                    end
                end
                default: state <= PCS_POWERUP;
            endcase
        end
    end

    // =====================================================================
    // Configuration flash, security and completion flag; reset models a
    // blank part, so it clears exactly what erase clears.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || erase_ok) begin
            secure    <= 1'b0;
            done_flag <= 1'b0;
            for (int i = 0; i < CFG_DEPTH; i++) begin
                cfg_mem[i] <= '0;
            end
        end else if (cmd_wr && !bad_cmd) begin
            case (cmd)
                PCS_CMD_PROGRAM:    cfg_mem[faddr] <= fdata;
                PCS_CMD_SET_SECURE: secure <= 1'b1;
                PCS_CMD_SET_DONE:   done_flag <= 1'b1;
                default:            secure <= secure;
            endcase
        end
    end
    // The loaded image feeds the logic array only; nothing reads it back.
    // Pins follow the loaded completion flag, so a background erase
    // cannot stop the running design.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            live_done <= 1'b0;
            for (int i = 0; i < CFG_DEPTH; i++) begin
                image[i] <= '0;
            end
        end else if (state == PCS_CONFIG && cnt == 32'h0000_0000) begin
            live_done <= done_flag;
            for (int i = 0; i < CFG_DEPTH; i++) begin
                image[i] <= cfg_mem[i];
            end
        end
    end

    for (genvar g = 0; g < CFG_DEPTH; g++) begin : g_img
        assign logic_image_out[g*DW +: DW] = image[g];
    end
    // =====================================================================
    // Software-visible registers
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            faddr <= 4'h0;
            fdata <= '0;
            uaddr <= 4'h0;
            psel  <= 8'h00;
            rdbk  <= '0;
        end else begin
            if (wr_take && address_in == PCS_OFS_ADDR) faddr <= writedata_in[3:0];
            if (wr_take && address_in == PCS_OFS_DATA) fdata <= writedata_in[DW-1:0];
            if (wr_take && address_in == PCS_OFS_UADDR) uaddr <= writedata_in[3:0];
            if (wr_take && address_in == PCS_OFS_PSEL) psel <= writedata_in[7:0];
            if (cmd_wr && cmd == PCS_CMD_VERIFY) begin
                rdbk <= bad_cmd ? '0 : cfg_mem[faddr];
            end
        end
    end
    // Refusal flag: a new refusal wins over a clear in the same cycle.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            refused <= 1'b0;
        end else if (bad_cmd) begin
            refused <= 1'b1;
        end else if (wr_take && address_in == PCS_OFS_STATUS &&
                     writedata_in[PCS_ST_REFUSED]) begin
            refused <= 1'b0;
        end
    end

    // =====================================================================
    // User flash: the bus wins when both sides write in one cycle.
    logic uf_bus_wr;
    assign uf_bus_wr = wr_take && address_in == PCS_OFS_UDATA;
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || erase_ok) begin
            for (int i = 0; i < UF_DEPTH; i++) begin
                uf[i] <= '0;
            end
        end else if (uf_bus_wr) begin
            uf[uaddr] <= writedata_in[DW-1:0];
        end else if (uf_write_in) begin
            uf[uf_addr_in] <= uf_wdata_in;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        uf_rdata_out <= rst_n_in ? uf[uf_addr_in] : '0;
    end
    // =====================================================================
    // Read data
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            readdata_out <= 32'h0000_0000;
        end else if (rd_cycle) begin
            readdata_out <= 32'h0000_0000;
            case (address_in)
                PCS_OFS_STATUS: readdata_out[PCS_ST_ARMED:0] <= {armed,
                    refused, id_ok, done_flag, secure, 1'b0, state};
                PCS_OFS_ADDR:  readdata_out[3:0] <= faddr;
                PCS_OFS_DATA:  readdata_out[DW-1:0] <= fdata;
                PCS_OFS_RDBK:  readdata_out[DW-1:0] <= rdbk;
                PCS_OFS_UADDR: readdata_out[3:0] <= uaddr;
                PCS_OFS_UDATA: readdata_out[DW-1:0] <= uf[uaddr];
                PCS_OFS_ID:    readdata_out <= PCS_ID_CODE;
                PCS_OFS_PSEL:  readdata_out[7:0] <= psel;
                PCS_OFS_PMODE: readdata_out[1:0] <= pin_mode[psel[2:0]];
                default:       readdata_out <= 32'h0000_0000;
            endcase
        end
    end
    // =====================================================================
    // Pin control
    logic user_drive;
    assign user_drive = (state == PCS_USER || state == PCS_BG) && live_done;
    assign user_clear_out = state == PCS_CLEAR;
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cap_val <= '0;
            cap_oe  <= '0;
            for (int i = 0; i < PINS; i++) begin
                pin_mode[i] <= PCS_PIN_TRI;
            end
        end else begin
            if (cmd_wr && !bad_cmd && cmd == PCS_CMD_ENTER_CLAMP) begin
                cap_val <= user_out_in;
                cap_oe  <= user_oe_in & {PINS{live_done}};
            end
            if (wr_take && address_in == PCS_OFS_PMODE) begin
                pin_mode[psel[2:0]] <= writedata_in[1:0];
            end
        end
    end
    for (genvar p = 0; p < PINS; p++) begin : g_pin
        logic nx_out;
        logic nx_oe;
        always_comb begin
            nx_out = 1'b0;
            nx_oe  = 1'b0;
            if (user_drive) begin
                nx_out = user_out_in[p];
                nx_oe  = user_oe_in[p];
            end else if (state == PCS_PROG && clamp_act) begin
                case (pin_mode[p])
                    PCS_PIN_CAPTURE: begin
                        nx_out = cap_val[p];
                        nx_oe  = cap_oe[p];
                    end
                    PCS_PIN_HIGH, PCS_PIN_LOW: begin
                        nx_out = pin_mode[p] == PCS_PIN_HIGH;
                        nx_oe  = 1'b1;
                    end
                    default: nx_oe = 1'b0;
                endcase
            end
        end
        // Registered pins trade one cycle of latency for glitch-free pads.
        always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
                pad_out[p]        <= 1'b0;
                pad_oe_out[p]     <= 1'b0;
                pad_pullup_out[p] <= 1'b1;
            end else begin
                pad_out[p]        <= nx_out;
                pad_oe_out[p]     <= nx_oe;
                pad_pullup_out[p] <= ~nx_oe;
            end
        end
    end

endmodule // pcs_top
